/* File: verilog/vpm_regs.sv */
// virtual partition id map registers 1 and 2 with access control
// Behaviour
// - map register 2 holds physical ids for virtual ids 8 to 11.
// - highest map register index input says which registers exist, up to 7.
// - index zero means only map register 0 exists here.
// - translate level1 ids only with level1 enable, level0 ids with level0.
// - entry n is used only when valid bit n is one.
// - map register 2 exists only with feature, control flag, index above 1.
// - no translation effect while the hypervisor level is disabled.
// - 64 bits; virtual 11 in 63:48 down to virtual 8 in 15:0.
// - mapping fields have unknown contents after reset.
// - encoding 3,4,10,6 with op2 1 or 2 selects map register 1 or 2.
// - any access at privilege level 0 is undefined.
// - level 1 with both nested bits redirects to memory 0x948 or 0x950.
// - level 1 nested bit only traps class 0x18 to 3 or 2; else undefined.
// - level 2 traps to 3 if enabled, else direct; level 3 always direct.
`timescale 1ns/1ps
module vpm_regs
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_op0,
	input wire logic [2:0] req_op1,
	input wire logic [3:0] req_crn,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_op2,
	input wire logic [63:0] req_wdata,
	input wire logic [1:0] current_level,
	input wire logic hypervisor_level_enabled,
	input wire logic nested_virt_bit,
	input wire logic nested_virt_memory_bit,
	input wire logic monitor_level_present,
	input wire logic trap_lower_levels,
	input wire logic feature_implemented,
	input wire logic has_hypervisor_control,
	input wire logic [2:0] highest_map_register_index,
	input wire logic level1_map_enable,
	input wire logic level0_map_enable,
	input wire logic [31:0] map_entry_valid_bits,
	input wire logic xlat_req,
	input wire logic xlat_from_level1,
	input wire logic [15:0] xlat_vid,
	output logic resp_valid_r,
	output vpm_pkg::vpm_res_t resp_kind_r,
	output logic [1:0] resp_trap_level_r,
	output logic [5:0] resp_trap_class_r,
	output logic [11:0] resp_mem_offset_r,
	output logic resp_write_r,
	output logic [63:0] resp_data_r,
	output logic xlat_valid_r,
	output logic xlat_hit_r,
	output logic [15:0] xlat_pid_r
);
	logic sel_enc;
	logic sel_map1;
	logic sel_map2;
	logic map1_present;
	logic map2_present;
	logic trap_high;
	vpm_pkg::vpm_res_t res_nxt;
	logic [1:0] trap_level_nxt;
	logic [11:0] mem_offset_nxt;
	logic direct_wr;
	logic direct_rd;
	logic [63:0] map1_value;
	logic [63:0] map2_value;
	logic [15:0] map1_field;
	logic [15:0] map2_field;
	logic vid_in_range;
	logic [2:0] vid_group;
	logic xlat_enabled;
	logic xlat_hit_nxt;
	logic [15:0] xlat_pid_nxt;

	// decode of the system register encoding
	assign sel_enc = req_valid && req_op0 == vpm_pkg::ENC_OP0
		&& req_op1 == vpm_pkg::ENC_OP1 && req_crn == vpm_pkg::ENC_CRN
		&& req_crm == vpm_pkg::ENC_CRM;
	assign sel_map1 = sel_enc && req_op2 == vpm_pkg::ENC_OP2_MAP1;
	assign sel_map2 = sel_enc && req_op2 == vpm_pkg::ENC_OP2_MAP2;

	// index zero leaves only register 0, so neither map here exists
	assign map1_present = feature_implemented && has_hypervisor_control
		&& highest_map_register_index > vpm_pkg::MAP1_MIN_INDEX;
	assign map2_present = feature_implemented && has_hypervisor_control
		&& highest_map_register_index > vpm_pkg::MAP2_MIN_INDEX;

	assign trap_high = monitor_level_present && trap_lower_levels;

	// access control outcome for a selected map register
	always_comb
	begin
		res_nxt = vpm_pkg::VPM_RES_UNDEF;
		trap_level_nxt = vpm_pkg::PRIV_LEVEL2;
		mem_offset_nxt = sel_map2 ? vpm_pkg::MEM_OFFSET_MAP2
			: vpm_pkg::MEM_OFFSET_MAP1;
		if ((sel_map1 && !map1_present) || (sel_map2 && !map2_present))
			res_nxt = vpm_pkg::VPM_RES_UNDEF;
		else
		begin
			unique case (current_level)
				vpm_pkg::PRIV_LEVEL0:
					res_nxt = vpm_pkg::VPM_RES_UNDEF;
				vpm_pkg::PRIV_LEVEL1:
				begin
					if (hypervisor_level_enabled && nested_virt_bit
						&& nested_virt_memory_bit)
						res_nxt = vpm_pkg::VPM_RES_MEM;
					else if (hypervisor_level_enabled && nested_virt_bit)
					begin
						res_nxt = vpm_pkg::VPM_RES_TRAP;
						trap_level_nxt = trap_high ? vpm_pkg::PRIV_LEVEL3
							: vpm_pkg::PRIV_LEVEL2;
					end
					else
						res_nxt = vpm_pkg::VPM_RES_UNDEF;
				end
				vpm_pkg::PRIV_LEVEL2:
				begin
					if (trap_high)
					begin
						res_nxt = vpm_pkg::VPM_RES_TRAP;
						trap_level_nxt = vpm_pkg::PRIV_LEVEL3;
					end
					else
						res_nxt = vpm_pkg::VPM_RES_DIRECT;
				end
				vpm_pkg::PRIV_LEVEL3:
					res_nxt = vpm_pkg::VPM_RES_DIRECT;
			endcase
		end
	end

	assign direct_wr = (sel_map1 || sel_map2) && req_write
		&& res_nxt == vpm_pkg::VPM_RES_DIRECT;
	assign direct_rd = (sel_map1 || sel_map2) && !req_write
		&& res_nxt == vpm_pkg::VPM_RES_DIRECT;

	vpm_map_reg u_map1
	(
		.clk_sys(clk_sys),
		.wr_en(direct_wr && sel_map1),
		.wr_data(req_wdata),
		.field_sel(xlat_vid[1:0]),
		.value(map1_value),
		.field(map1_field)
	);

	vpm_map_reg u_map2
	(
		.clk_sys(clk_sys),
		.wr_en(direct_wr && sel_map2),
		.wr_data(req_wdata),
		.field_sel(xlat_vid[1:0]),
		.value(map2_value),
		.field(map2_field)
	);

	// answer to every selected access, one cycle after the request
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			resp_valid_r <= 1'b0;
			resp_kind_r <= vpm_pkg::VPM_RES_UNDEF;
			resp_trap_level_r <= vpm_pkg::PRIV_LEVEL0;
			resp_trap_class_r <= vpm_pkg::CLASS_RST;
			resp_mem_offset_r <= vpm_pkg::OFFSET_RST;
			resp_write_r <= 1'b0;
		end
		else
		begin
			resp_valid_r <= sel_map1 || sel_map2;
			resp_kind_r <= res_nxt;
			resp_trap_level_r <= trap_level_nxt;
			resp_trap_class_r <= vpm_pkg::TRAP_CLASS;
			resp_mem_offset_r <= mem_offset_nxt;
			resp_write_r <= req_write;
		end
	end

	// read data for direct reads, write data for memory redirected writes
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			resp_data_r <= vpm_pkg::DATA_RST;
		else if (direct_rd)
			resp_data_r <= sel_map2 ? map2_value : map1_value;
		else if ((sel_map1 || sel_map2) && req_write
			&& res_nxt == vpm_pkg::VPM_RES_MEM)
			resp_data_r <= req_wdata;
		else
			resp_data_r <= vpm_pkg::DATA_RST;
	end

	// translation of virtual ids 4..11 to physical ids
	assign vid_group = xlat_vid[4:2];
	assign vid_in_range = xlat_vid[15:5] == vpm_pkg::VID_HIGH_ZERO
		&& ((vid_group == vpm_pkg::MAP1_VID_GROUP && map1_present)
		|| (vid_group == vpm_pkg::MAP2_VID_GROUP && map2_present));
	assign xlat_enabled = hypervisor_level_enabled
		&& (xlat_from_level1 ? level1_map_enable
		: level0_map_enable);

	always_comb
	begin
		xlat_hit_nxt = xlat_enabled && vid_in_range
			&& map_entry_valid_bits[xlat_vid[4:0]];
		if (xlat_hit_nxt)
			xlat_pid_nxt = vid_group == vpm_pkg::MAP2_VID_GROUP
				? map2_field : map1_field;
		else
			xlat_pid_nxt = xlat_vid;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			xlat_valid_r <= 1'b0;
			xlat_hit_r <= 1'b0;
			xlat_pid_r <= vpm_pkg::PID_RST;
		end
		else
		begin
			xlat_valid_r <= xlat_req;
			xlat_hit_r <= xlat_req && xlat_hit_nxt;
			xlat_pid_r <= xlat_pid_nxt;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_level0_undef: assert property (
		(sel_map1 || sel_map2) && current_level == vpm_pkg::PRIV_LEVEL0
		|=> resp_valid_r && resp_kind_r == vpm_pkg::VPM_RES_UNDEF)
		else $error("level 0 access not undefined");

	chk_absent_map2: assert property (
		sel_map2 && highest_map_register_index <= vpm_pkg::MAP2_MIN_INDEX
		|=> resp_valid_r && resp_kind_r == vpm_pkg::VPM_RES_UNDEF)
		else $error("absent map register 2 accessed");

	chk_index_zero: assert property (
		sel_map1 && highest_map_register_index == 3'h0
		|=> resp_kind_r == vpm_pkg::VPM_RES_UNDEF)
		else $error("map register 1 present with index zero");

	chk_mem_offset: assert property (
		sel_map2 && map2_present && current_level == vpm_pkg::PRIV_LEVEL1
		&& hypervisor_level_enabled && nested_virt_bit
		&& nested_virt_memory_bit
		|=> resp_kind_r == vpm_pkg::VPM_RES_MEM
		&& resp_mem_offset_r == 12'h950)
		else $error("memory redirect wrong");

	chk_trap_target: assert property (
		(sel_map1 && map1_present || sel_map2 && map2_present)
		&& current_level == vpm_pkg::PRIV_LEVEL1
		&& hypervisor_level_enabled && nested_virt_bit
		&& !nested_virt_memory_bit
		|=> resp_kind_r == vpm_pkg::VPM_RES_TRAP && resp_trap_class_r == 6'h18
		&& resp_trap_level_r == ($past(trap_high) ? 2'h3 : 2'h2))
		else $error("level 1 trap wrong");

	chk_level2_trap: assert property (
		sel_map2 && map2_present && current_level == vpm_pkg::PRIV_LEVEL2
		&& monitor_level_present && trap_lower_levels
		|=> resp_kind_r == vpm_pkg::VPM_RES_TRAP && resp_trap_level_r == 2'h3)
		else $error("level 2 trap to level 3 missing");

	chk_level3_direct: assert property (
		sel_map2 && map2_present && current_level == vpm_pkg::PRIV_LEVEL3
		|=> resp_kind_r == vpm_pkg::VPM_RES_DIRECT)
		else $error("level 3 access not direct");

	chk_write_read: assert property (
		direct_wr && sel_map2 ##1 !direct_wr ##1 direct_rd && sel_map2
		|=> resp_data_r == $past(req_wdata, 3))
		else $error("read after write mismatch");

	chk_field_top: assert property (
		xlat_req && xlat_hit_nxt && xlat_vid == 16'h000b
		|=> xlat_hit_r && xlat_pid_r == $past(map2_value[63:48]))
		else $error("virtual 11 not from top field");

	chk_disabled_gate: assert property (
		xlat_req && !hypervisor_level_enabled |=> !xlat_hit_r)
		else $error("translation while hypervisor disabled");

	chk_invalid_entry: assert property (
		xlat_req && !map_entry_valid_bits[xlat_vid[4:0]]
		|=> !xlat_hit_r && xlat_pid_r == $past(xlat_vid))
		else $error("invalid entry used");

	chk_enable_select: assert property (
		xlat_req && (xlat_from_level1 ? !level1_map_enable
		: !level0_map_enable) |=> !xlat_hit_r)
		else $error("translation without enable");

	cov_direct_write: cover property (direct_wr && sel_map2);
	cov_mem_redirect: cover property (
		resp_valid_r && resp_kind_r == vpm_pkg::VPM_RES_MEM);
	cov_trap: cover property (
		resp_valid_r && resp_kind_r == vpm_pkg::VPM_RES_TRAP);
	cov_xlat_hit: cover property (xlat_hit_r);
endmodule // vpm_regs

/* File: include/vpm_pkg.sv */
// constants and types shared by the partition id map register bank
package vpm_pkg;
	localparam int MAP_WIDTH = 64;
	localparam int PID_WIDTH = 16;
	localparam int VALID_BITS = 32;

	// system register encoding of the map registers
	localparam logic [1:0] ENC_OP0 = 2'h3;
	localparam logic [2:0] ENC_OP1 = 3'h4;
	localparam logic [3:0] ENC_CRN = 4'ha;
	localparam logic [3:0] ENC_CRM = 4'h6;
	localparam logic [2:0] ENC_OP2_MAP1 = 3'h1;
	localparam logic [2:0] ENC_OP2_MAP2 = 3'h2;

	// a map register exists when the highest index exceeds this value
	localparam logic [2:0] MAP1_MIN_INDEX = 3'h0;
	localparam logic [2:0] MAP2_MIN_INDEX = 3'h1;

	// offsets in the nested virtualisation memory page
	localparam logic [11:0] MEM_OFFSET_MAP1 = 12'h948;
	localparam logic [11:0] MEM_OFFSET_MAP2 = 12'h950;

	localparam logic [5:0] TRAP_CLASS = 6'h18;

	localparam logic [1:0] PRIV_LEVEL0 = 2'h0;
	localparam logic [1:0] PRIV_LEVEL1 = 2'h1;
	localparam logic [1:0] PRIV_LEVEL2 = 2'h2;
	localparam logic [1:0] PRIV_LEVEL3 = 2'h3;

	// virtual ids 4..7 and 8..11 as groups of bits [4:2]
	localparam logic [2:0] MAP1_VID_GROUP = 3'h1;
	localparam logic [2:0] MAP2_VID_GROUP = 3'h2;
	localparam logic [10:0] VID_HIGH_ZERO = 11'h000;

	// values after reset of the answer and translation outputs
	localparam logic [63:0] DATA_RST = 64'h0;
	localparam logic [15:0] PID_RST = 16'h0;
	localparam logic [11:0] OFFSET_RST = 12'h000;
	localparam logic [5:0] CLASS_RST = 6'h00;

	typedef enum logic [3:0] {
		VPM_RES_DIRECT = 4'b0001,
		VPM_RES_UNDEF = 4'b0010,
		VPM_RES_TRAP = 4'b0100,
		VPM_RES_MEM = 4'b1000
	} vpm_res_t;
endpackage

/* File: verilog/vpm_map_reg.sv */
// one 64-bit map register of four 16-bit physical id fields
`timescale 1ns/1ps
module vpm_map_reg
(
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [vpm_pkg::MAP_WIDTH-1:0] wr_data,
	input wire logic [1:0] field_sel,
	output logic [vpm_pkg::MAP_WIDTH-1:0] value,
	output logic [vpm_pkg::PID_WIDTH-1:0] field
);
	logic [vpm_pkg::MAP_WIDTH-1:0] map_r;

	// storage carries no reset: contents are unknown until written
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			map_r <= wr_data;
	end

	assign value = map_r;

	// field n occupies bits [16n+15:16n]
	always_comb
	begin
		unique case (field_sel)
			2'h0: field = map_r[15:0];
			2'h1: field = map_r[31:16];
			2'h2: field = map_r[47:32];
			2'h3: field = map_r[63:48];
		endcase
	end
endmodule // vpm_map_reg

/* File: sim/vpm_core_model.sv */
// processor core model issuing system register moves to the map bank
`timescale 1ns/1ps
module vpm_core_model
(
	input wire logic clk_sys,
	output logic req_valid,
	output logic req_write,
	output logic [1:0] req_op0,
	output logic [2:0] req_op1,
	output logic [3:0] req_crn,
	output logic [3:0] req_crm,
	output logic [2:0] req_op2,
	output logic [63:0] req_wdata,
	output logic [1:0] current_level
);
	initial
	begin
		req_valid = 1'b0;
		req_write = 1'b0;
		{req_op0, req_op1, req_crn, req_crm, req_op2} = 16'h0000;
		req_wdata = 64'h0;
		current_level = 2'h0;
	end

	// one move, valid for a single rising edge, then data scrambled
	task automatic move(input logic wr, input logic [1:0] lvl,
		input logic [2:0] op2, input logic [63:0] d);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_write = wr;
		req_op0 = vpm_pkg::ENC_OP0;
		req_op1 = vpm_pkg::ENC_OP1;
		req_crn = vpm_pkg::ENC_CRN;
		req_crm = vpm_pkg::ENC_CRM;
		req_op2 = op2;
		req_wdata = d;
		current_level = lvl;
		@(negedge clk_sys);
		req_valid = 1'b0;
		req_op2 = ~op2;
		req_wdata = ~d;
	endtask
endmodule // vpm_core_model

/* File: sim/testbench.sv */
// self-checking bench for the partition id map register bank
`timescale 1ns/1ps
module testbench;
	localparam vpm_pkg::vpm_res_t DIR = vpm_pkg::VPM_RES_DIRECT;
	localparam vpm_pkg::vpm_res_t UND = vpm_pkg::VPM_RES_UNDEF;
	localparam vpm_pkg::vpm_res_t TRP = vpm_pkg::VPM_RES_TRAP;
	localparam vpm_pkg::vpm_res_t MEM = vpm_pkg::VPM_RES_MEM;
	localparam logic [63:0] D = 64'h0b0b_0a0a_0909_0808;
	localparam logic [63:0] E = 64'h1234_5678_9abc_def0;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hyp = 1'b1, nv = 1'b0, nv2 = 1'b0, mon = 1'b0, tl = 1'b0;
	logic feat = 1'b1, hcr = 1'b1, en1 = 1'b1, en0 = 1'b0;
	logic [2:0] idx = 3'h2;
	logic [31:0] vbits = 32'h0000_0f00;
	logic xreq = 1'b0, xsrc = 1'b0;
	logic [15:0] xvid = 16'h0000;
	logic req_valid, req_write, resp_valid_r, resp_write_r;
	logic [1:0] req_op0, current_level, resp_trap_level_r;
	logic [2:0] req_op1, req_op2;
	logic [3:0] req_crn, req_crm;
	logic [63:0] req_wdata, resp_data_r;
	vpm_pkg::vpm_res_t resp_kind_r;
	logic [5:0] resp_trap_class_r;
	logic [11:0] resp_mem_offset_r;
	logic xlat_valid_r, xlat_hit_r;
	logic [15:0] xlat_pid_r;
	int failures = 0;
	int n_compared = 0;

	vpm_core_model vpm_core_model_i (.clk_sys(clk_sys),
		.req_valid(req_valid), .req_write(req_write), .req_op0(req_op0),
		.req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm),
		.req_op2(req_op2), .req_wdata(req_wdata),
		.current_level(current_level));

	vpm_regs vpm_regs_i (.clk_sys(clk_sys), .rst(rst),
		.req_valid(req_valid), .req_write(req_write), .req_op0(req_op0),
		.req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm),
		.req_op2(req_op2), .req_wdata(req_wdata),
		.current_level(current_level), .hypervisor_level_enabled(hyp),
		.nested_virt_bit(nv), .nested_virt_memory_bit(nv2),
		.monitor_level_present(mon), .trap_lower_levels(tl),
		.feature_implemented(feat), .has_hypervisor_control(hcr),
		.highest_map_register_index(idx), .level1_map_enable(en1),
		.level0_map_enable(en0), .map_entry_valid_bits(vbits),
		.xlat_req(xreq), .xlat_from_level1(xsrc), .xlat_vid(xvid),
		.resp_valid_r(resp_valid_r), .resp_kind_r(resp_kind_r),
		.resp_trap_level_r(resp_trap_level_r),
		.resp_trap_class_r(resp_trap_class_r),
		.resp_mem_offset_r(resp_mem_offset_r), .resp_write_r(resp_write_r),
		.resp_data_r(resp_data_r), .xlat_valid_r(xlat_valid_r),
		.xlat_hit_r(xlat_hit_r), .xlat_pid_r(xlat_pid_r));

	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_kind(input vpm_pkg::vpm_res_t got,
		input vpm_pkg::vpm_res_t exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t kind %b expected %b", $time, got, exp);
		end
	endtask

	// access, then check the answer seen one edge later
	task automatic acc(input logic wr, input logic [1:0] lvl,
		input logic [2:0] op2, input logic [63:0] d,
		input vpm_pkg::vpm_res_t k, input logic [63:0] ed);
		vpm_core_model_i.move(wr, lvl, op2, d);
		cmp({63'h0, resp_valid_r}, 64'h1);
		cmp({63'h0, resp_write_r}, {63'h0, wr});
		cmp_kind(resp_kind_r, k);
		cmp(resp_data_r, ed);
	endtask

	task automatic xl(input logic src, input logic [15:0] vid,
		input logic hit, input logic [15:0] pid);
		@(negedge clk_sys);
		xreq = 1'b1;
		xsrc = src;
		xvid = vid;
		@(negedge clk_sys);
		xreq = 1'b0;
		xvid = ~vid;
		cmp({63'h0, xlat_valid_r}, 64'h1);
		cmp({63'h0, xlat_hit_r}, {63'h0, hit});
		cmp({48'h0, xlat_pid_r}, {48'h0, pid});
	endtask

	initial
	begin
		#100us;
		failures++;
		test_done();
	end

	initial
	begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		acc(1'b1, 2'h3, 3'h2, D, DIR, 64'h0);
		acc(1'b0, 2'h3, 3'h2, 64'h0, DIR, D);
		acc(1'b1, 2'h2, 3'h1, E, DIR, 64'h0);
		acc(1'b0, 2'h2, 3'h1, 64'h0, DIR, E);
		acc(1'b0, 2'h3, 3'h2, 64'h0, DIR, D);
		mon = 1'b1;
		tl = 1'b1;
		acc(1'b1, 2'h2, 3'h2, E, TRP, 64'h0);
		cmp({62'h0, resp_trap_level_r}, 64'h3);
		cmp({58'h0, resp_trap_class_r}, 64'h18);
		acc(1'b0, 2'h3, 3'h2, 64'h0, DIR, D);
		acc(1'b0, 2'h0, 3'h2, 64'h0, UND, 64'h0);
		nv = 1'b1;
		nv2 = 1'b1;
		acc(1'b1, 2'h1, 3'h2, E, MEM, E);
		cmp({52'h0, resp_mem_offset_r}, 64'h950);
		acc(1'b0, 2'h1, 3'h1, 64'h0, MEM, 64'h0);
		cmp({52'h0, resp_mem_offset_r}, 64'h948);
		nv2 = 1'b0;
		acc(1'b0, 2'h1, 3'h2, 64'h0, TRP, 64'h0);
		cmp({62'h0, resp_trap_level_r}, 64'h3);
		tl = 1'b0;
		acc(1'b0, 2'h1, 3'h2, 64'h0, TRP, 64'h0);
		cmp({62'h0, resp_trap_level_r}, 64'h2);
		hyp = 1'b0;
		acc(1'b0, 2'h1, 3'h2, 64'h0, UND, 64'h0);
		nv = 1'b0;
		hyp = 1'b1;
		acc(1'b0, 2'h1, 3'h2, 64'h0, UND, 64'h0);
		idx = 3'h1;
		acc(1'b0, 2'h3, 3'h2, 64'h0, UND, 64'h0);
		acc(1'b0, 2'h3, 3'h1, 64'h0, DIR, E);
		idx = 3'h0;
		acc(1'b0, 2'h3, 3'h1, 64'h0, UND, 64'h0);
		idx = 3'h7;
		hcr = 1'b0;
		acc(1'b0, 2'h3, 3'h2, 64'h0, UND, 64'h0);
		hcr = 1'b1;
		feat = 1'b0;
		acc(1'b0, 2'h3, 3'h2, 64'h0, UND, 64'h0);
		feat = 1'b1;
		acc(1'b0, 2'h3, 3'h2, 64'h0, DIR, D);
		for (int v = 8; v < 12; v++)
			xl(1'b1, 16'(v), 1'b1, D[16*(v-8) +: 16]);
		vbits = 32'h0000_1f20;
		xl(1'b1, 16'h0005, 1'b1, E[31:16]);
		xl(1'b1, 16'h000c, 1'b0, 16'h000c);
		vbits = 32'h0000_0d00;
		xl(1'b1, 16'h0009, 1'b0, 16'h0009);
		en1 = 1'b0;
		xl(1'b1, 16'h0008, 1'b0, 16'h0008);
		en0 = 1'b1;
		xl(1'b0, 16'h0008, 1'b1, D[15:0]);
		hyp = 1'b0;
		xl(1'b0, 16'h0008, 1'b0, 16'h0008);
		test_done();
	end
endmodule // testbench
